// ==== rtl/seq_pkg.sv ====
// constants, state codes and timing counts for the dual regulator sequencer
// assumes a single 50 MHz core clock and no register bus
package seq_pkg;

  // clock and time base
  localparam int unsigned CLK_PERIOD_NS  = 20;
  localparam int unsigned TIMEBASE_US    = 1000;
  localparam int unsigned SC_DEBOUNCE_US = 1000;
  localparam int unsigned MS_CYCLES      = (TIMEBASE_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned SC_CYCLES      = (SC_DEBOUNCE_US * 1000) / CLK_PERIOD_NS;

  // widths
  localparam int unsigned NUM_REG    = 2;
  localparam int unsigned NUM_AUX    = 2;
  localparam int unsigned NUM_CHAN   = NUM_REG + NUM_AUX;
  localparam int unsigned DELAY_W    = 4;
  localparam int unsigned VCODE_W    = 8;
  localparam int unsigned TIMER_W    = 16;

  // channel index of the first auxiliary output
  localparam int unsigned AUX_BASE   = NUM_REG;

  // reset values
  localparam logic          IRQ_IDLE_N   = 1'b1;
  localparam logic [7:0]    VCODE_OFF    = 8'h00;
  localparam logic [3:0]    DELAY_DONE   = 4'h0;

  // device operating states
  typedef enum logic [1:0] {
    ST_DOWN = 2'b00,
    ST_LOAD = 2'b01,
    ST_FLAG = 2'b10,
    ST_RUN  = 2'b11
  } dev_state_e;

endpackage : seq_pkg

// ==== rtl/dual_regulator_sequencer_irq.sv ====
// sequencing, reset handling and event flags of the dual regulator device
// assumes all inputs synchronous to clock; config bits arrive as plain ports
`timescale 1ns/100ps

// What this block does
// RULE1: regulator sequenced only if on and pin-selected
// RULE2: regulator turns on after its rise delay
// RULE3: regulator turns off after its fall delay
// RULE4: enabled pin regulator targets its voltage code
// RULE5: aux output sequenced only if on and selected
// RULE6: aux output rises after its rise delay
// RULE7: aux output falls after its fall delay
// RULE8: delays only for pin edges, bits act immediately
// RULE9: soft reset pulse starts reset, self clearing
// RULE10: soft reset kills outputs, defaults, reloads fuses
// RULE11: host interface state survives soft reset
// RULE12: supply undervoltage kills outputs, resets state
// RULE13: supply recovery reloads fuses then starts up
// RULE14: irq low while any unmasked flag pending
// RULE15: reset flag raised at start-up unless masked
// RULE16: reset mask reloaded from fuses every reset
// RULE17: current limit flag clears only when inactive
// RULE18: low output for 1 ms disables regulator
// RULE19: hot warning flags; hot shutdown kills outputs
// RULE20: overvoltage kills outputs, flag sticks while present
// RULE21: output valid either direction sets one flag
// RULE22: rails ok drop sets maskable flag
// RULE23: polarity inverts pin only, not state
// RULE24: clock flag on change or missing clock
// RULE25: delays timed by millisecond timebase counters
module dual_regulator_sequencer_irq #(
  parameter int unsigned MS_CYCLES = seq_pkg::MS_CYCLES,
  parameter int unsigned SC_CYCLES = seq_pkg::SC_CYCLES
) (
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic        seqEnablePin,
  input  wire logic        analogSupplyLow,
  input  wire logic        softResetBit,
  input  wire logic        otpResetMask,
  input  wire logic [1:0]  regulatorOnBit,
  input  wire logic [1:0]  regulatorPinSelect,
  input  wire logic [7:0]  regulatorVoltageCode0,
  input  wire logic [7:0]  regulatorVoltageCode1,
  input  wire logic [3:0]  regulatorRiseDelay0,
  input  wire logic [3:0]  regulatorRiseDelay1,
  input  wire logic [3:0]  regulatorFallDelay0,
  input  wire logic [3:0]  regulatorFallDelay1,
  input  wire logic [1:0]  auxOutputOnBit,
  input  wire logic [1:0]  auxOutputPinSelect,
  input  wire logic [3:0]  auxOutputRiseDelay0,
  input  wire logic [3:0]  auxOutputRiseDelay1,
  input  wire logic [3:0]  auxOutputFallDelay0,
  input  wire logic [3:0]  auxOutputFallDelay1,
  input  wire logic [1:0]  currentLimitIn,
  input  wire logic [1:0]  outputLow,
  input  wire logic [1:0]  outputValidIn,
  input  wire logic        hotWarningIn,
  input  wire logic        hotShutdownIn,
  input  wire logic        supplyOvervoltIn,
  input  wire logic        clockDetectEnable,
  input  wire logic        extClockPresent,
  input  wire logic [1:0]  currentLimitMask,
  input  wire logic [1:0]  outputValidRiseMask,
  input  wire logic [1:0]  outputValidFallMask,
  input  wire logic        hotWarningMask,
  input  wire logic        railsOkDropMask,
  input  wire logic        extClockMask,
  input  wire logic        railsOkPolarity,
  input  wire logic [1:0]  currentLimitClear,
  input  wire logic [1:0]  shortCircuitClear,
  input  wire logic [1:0]  outputValidChangeClear,
  input  wire logic        hotWarningClear,
  input  wire logic        hotShutdownClear,
  input  wire logic        supplyOvervoltClear,
  input  wire logic        railsOkDropClear,
  input  wire logic        extClockClear,
  input  wire logic        resetIndicationClear,
  output logic      [1:0]  regulatorEnable,
  output logic      [7:0]  regulatorVoltage0,
  output logic      [7:0]  regulatorVoltage1,
  output logic             auxOutput0,
  output logic             auxOutput1,
  output logic             irqOutN,
  output logic             railsOkPin,
  output logic             railsOkState,
  output logic      [1:0]  currentLimitState,
  output logic      [1:0]  outputValidState,
  output logic             hotWarningState,
  output logic             hotShutdownState,
  output logic             supplyOvervoltState,
  output logic             extClockState,
  output logic      [1:0]  currentLimitFlag,
  output logic      [1:0]  shortCircuitFlag,
  output logic      [1:0]  outputValidChangeFlag,
  output logic             hotWarningFlag,
  output logic             hotShutdownFlag,
  output logic             supplyOvervoltFlag,
  output logic             railsOkDropFlag,
  output logic             extClockFlag,
  output logic             resetIndicationFlag,
  output logic             deviceRunning
);

  localparam logic [seq_pkg::TIMER_W-1:0] MS_LAST = seq_pkg::TIMER_W'(MS_CYCLES - 1);
  localparam logic [seq_pkg::TIMER_W-1:0] SC_LAST = seq_pkg::TIMER_W'(SC_CYCLES - 1);

  typedef struct packed {
    seq_pkg::dev_state_e           st;
    logic [seq_pkg::TIMER_W-1:0]   msCnt;
    logic                          enPrev;
    logic [3:0]                    seqOn;
    logic [3:0]                    pend;
    logic [3:0]                    tgt;
    logic [3:0][3:0]               dly;
    logic [1:0][15:0]              scCnt;
    logic                          resetMask;
    logic [1:0]                    regOn;
    logic [1:0][7:0]               regVolt;
    logic [1:0]                    auxOut;
    logic                          irqN;
    logic                          railsPin;
    logic                          railsOk;
    logic [1:0]                    ilimSt;
    logic [1:0]                    pgSt;
    logic                          hotWarnSt;
    logic                          hotSdSt;
    logic                          ovSt;
    logic                          clkSt;
    logic [1:0]                    ilimFlag;
    logic [1:0]                    scFlag;
    logic [1:0]                    pgFlag;
    logic                          hotWarnFlag;
    logic                          hotSdFlag;
    logic                          ovFlag;
    logic                          railsDropFlag;
    logic                          clkFlag;
    logic                          resetFlag;
  } state_s;

  // reset image: everything off, irq released, fuse load pending
  localparam state_s RESET_VAL = '{
    st:       seq_pkg::ST_LOAD,
    msCnt:    MS_LAST,
    irqN:     seq_pkg::IRQ_IDLE_N,
    railsPin: 1'b0,
    default:  '0
  };

  state_s state_q;
  state_s state_d;

  logic [3:0]       onBit;
  logic [3:0]       pinSel;
  logic [3:0][3:0]  riseDly;
  logic [3:0][3:0]  fallDly;
  logic [1:0][7:0]  vCode;

  assign onBit   = {auxOutputOnBit, regulatorOnBit};
  assign pinSel  = {auxOutputPinSelect, regulatorPinSelect};
  assign riseDly = {auxOutputRiseDelay1, auxOutputRiseDelay0,
                    regulatorRiseDelay1, regulatorRiseDelay0};
  assign fallDly = {auxOutputFallDelay1, auxOutputFallDelay0,
                    regulatorFallDelay1, regulatorFallDelay0};
  assign vCode   = {regulatorVoltageCode1, regulatorVoltageCode0};

  always_comb begin
    logic       tick;
    logic       enRise;
    logic       enFall;
    logic       kill;
    logic       running;
    logic [3:0] chanOn;
    logic       railsOkNow;
    logic       anyIrq;
    tick       = 1'b0;
    enRise     = 1'b0;
    enFall     = 1'b0;
    kill       = 1'b0;
    running    = 1'b0;
    chanOn     = '0;
    railsOkNow = 1'b0;
    anyIrq     = 1'b0;
    state_d    = state_q;

    running = (state_q.st == seq_pkg::ST_RUN);

    // millisecond timebase, restarted on every pin edge
    tick          = (state_q.msCnt == '0);
    enRise        = seqEnablePin & ~state_q.enPrev;
    enFall        = ~seqEnablePin & state_q.enPrev;
    state_d.msCnt = tick ? MS_LAST : state_q.msCnt - 1'b1; // [RULE25]
    if (enRise | enFall) begin
      state_d.msCnt = MS_LAST; // [RULE25]
    end
    state_d.enPrev = seqEnablePin;
    // global shutdown from hot shutdown or overvoltage
    kill = hotShutdownIn | supplyOvervoltIn |
           state_q.hotSdFlag | state_q.ovFlag; // [RULE19] [RULE20]

    // per channel delayed sequencing
    for (int i = 0; i < 4; i++) begin
      if (enRise) begin
        state_d.pend[i] = 1'b1;
        state_d.tgt[i]  = 1'b1;
        state_d.dly[i]  = riseDly[i]; // [RULE2] [RULE6]
      end else if (enFall) begin
        state_d.pend[i] = 1'b1;
        state_d.tgt[i]  = 1'b0;
        state_d.dly[i]  = fallDly[i]; // [RULE3] [RULE7]
      end else if (state_q.pend[i]) begin
        if (state_q.dly[i] == seq_pkg::DELAY_DONE) begin
          state_d.seqOn[i] = state_q.tgt[i];
          state_d.pend[i]  = 1'b0;
        end else if (tick) begin
          state_d.dly[i] = state_q.dly[i] - 1'b1; // [RULE25]
        end
      end
      if (kill) begin
        state_d.seqOn[i] = 1'b0;
        state_d.pend[i]  = 1'b0;
      end
      // bit control acts at once; pin control needs both bits
      chanOn[i] = onBit[i] & (pinSel[i] ? state_q.seqOn[i] : 1'b1); // [RULE1] [RULE5] [RULE8]
    end

    // status mirrors
    state_d.ilimSt    = currentLimitIn;
    state_d.pgSt      = outputValidIn;
    state_d.hotWarnSt = hotWarningIn;
    state_d.hotSdSt   = hotShutdownIn;
    state_d.ovSt      = supplyOvervoltIn;
    state_d.clkSt     = extClockPresent;

    // regulator outputs and short circuit debounce
    for (int r = 0; r < 2; r++) begin
      if (state_q.regOn[r] & outputLow[r]) begin
        if (state_q.scCnt[r] == SC_LAST) begin
          state_d.scFlag[r] = 1'b1; // [RULE18]
        end else begin
          state_d.scCnt[r] = state_q.scCnt[r] + 1'b1;
        end
      end else begin
        state_d.scCnt[r] = '0;
      end
      if (state_q.scFlag[r] & shortCircuitClear[r]) begin
        state_d.scFlag[r] = state_d.scCnt[r] == SC_LAST && state_q.regOn[r] && outputLow[r];
      end
      state_d.regOn[r]   = chanOn[r] & ~kill & ~state_d.scFlag[r]; // [RULE18]
      state_d.regVolt[r] = state_d.regOn[r] ? vCode[r] : seq_pkg::VCODE_OFF; // [RULE4]
    end
    for (int a = 0; a < 2; a++) begin
      state_d.auxOut[a] = chanOn[seq_pkg::AUX_BASE + a] & ~kill; // [RULE6] [RULE7]
    end

    // current limit: sticky while active
    state_d.ilimFlag = currentLimitIn |
                       (state_q.ilimFlag & ~(currentLimitClear & ~currentLimitIn)); // [RULE17]

    // output valid change, either direction through its own mask
    state_d.pgFlag = (outputValidIn & ~state_q.pgSt & ~outputValidRiseMask) |
                     (~outputValidIn & state_q.pgSt & ~outputValidFallMask) |
                     (state_q.pgFlag & ~outputValidChangeClear); // [RULE21]

    // thermal and overvoltage flags hold while the condition stands
    state_d.hotWarnFlag = hotWarningIn |
                          (state_q.hotWarnFlag & ~hotWarningClear); // [RULE19]
    state_d.hotSdFlag   = hotShutdownIn |
                          (state_q.hotSdFlag & ~hotShutdownClear); // [RULE19]
    state_d.ovFlag      = supplyOvervoltIn |
                          (state_q.ovFlag & ~supplyOvervoltClear); // [RULE20]

    // rails ok: enabled regulators valid, no overvolt or hot shutdown
    railsOkNow = (&(outputValidIn | ~state_q.regOn)) & ~state_q.ovFlag & ~state_q.hotSdFlag;
    state_d.railsOk  = railsOkNow; // [RULE23]
    state_d.railsPin = railsOkNow ^ railsOkPolarity; // [RULE23]
    state_d.railsDropFlag = (state_q.railsOk & ~railsOkNow) |
                            (state_q.railsDropFlag & ~railsOkDropClear); // [RULE22]

    // external clock detector
    state_d.clkFlag = (clockDetectEnable &
                       ((extClockPresent ^ state_q.clkSt) | ~extClockPresent)) |
                      (state_q.clkFlag & ~extClockClear); // [RULE24]

    // reset indication clear
    state_d.resetFlag = state_q.resetFlag & ~resetIndicationClear;

    // interrupt pin
    anyIrq = (|(state_q.ilimFlag & ~currentLimitMask)) |
             (|state_q.scFlag) |
             (|state_q.pgFlag) |
             (state_q.hotWarnFlag & ~hotWarningMask) |
             state_q.hotSdFlag |
             state_q.ovFlag |
             (state_q.railsDropFlag & ~railsOkDropMask) |
             (state_q.clkFlag & ~extClockMask) |
             state_q.resetFlag;
    state_d.irqN = ~anyIrq; // [RULE14]

    // operating state sequence
    case (state_q.st)
      seq_pkg::ST_DOWN: begin
        state_d    = RESET_VAL;
        state_d.st = seq_pkg::ST_LOAD; // [RULE13]
      end
      seq_pkg::ST_LOAD: begin
        state_d           = RESET_VAL;
        state_d.resetMask = otpResetMask; // [RULE16]
        state_d.st        = seq_pkg::ST_FLAG;
      end
      seq_pkg::ST_FLAG: begin
        state_d           = RESET_VAL;
        state_d.resetMask = state_q.resetMask;
        state_d.resetFlag = ~state_q.resetMask; // [RULE15]
        state_d.st        = seq_pkg::ST_RUN; // [RULE13]
      end
      seq_pkg::ST_RUN: begin
        state_d.st = seq_pkg::ST_RUN;
      end
      default: begin
        state_d = RESET_VAL;
      end
    endcase
    if (!running) begin
      state_d.enPrev = 1'b0;
    end

    // soft reset pulse: defaults, then fuse reload; no host state lives here
    if (softResetBit) begin
      state_d = RESET_VAL; // [RULE9] [RULE10] [RULE11]
    end

    // undervoltage holds everything at defaults until supply returns
    if (analogSupplyLow) begin
      state_d    = RESET_VAL; // [RULE12]
      state_d.st = seq_pkg::ST_DOWN;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= RESET_VAL;
    end else begin
      state_q <= state_d;
    end
  end

  assign regulatorEnable       = state_q.regOn;
  assign regulatorVoltage0     = state_q.regVolt[0];
  assign regulatorVoltage1     = state_q.regVolt[1];
  assign auxOutput0            = state_q.auxOut[0];
  assign auxOutput1            = state_q.auxOut[1];
  assign irqOutN               = state_q.irqN;
  assign railsOkPin            = state_q.railsPin;
  assign railsOkState          = state_q.railsOk;
  assign currentLimitState     = state_q.ilimSt;
  assign outputValidState      = state_q.pgSt;
  assign hotWarningState       = state_q.hotWarnSt;
  assign hotShutdownState      = state_q.hotSdSt;
  assign supplyOvervoltState   = state_q.ovSt;
  assign extClockState         = state_q.clkSt;
  assign currentLimitFlag      = state_q.ilimFlag;
  assign shortCircuitFlag      = state_q.scFlag;
  assign outputValidChangeFlag = state_q.pgFlag;
  assign hotWarningFlag        = state_q.hotWarnFlag;
  assign hotShutdownFlag       = state_q.hotSdFlag;
  assign supplyOvervoltFlag    = state_q.ovFlag;
  assign railsOkDropFlag       = state_q.railsDropFlag;
  assign extClockFlag          = state_q.clkFlag;
  assign resetIndicationFlag   = state_q.resetFlag;
  assign deviceRunning         = (state_q.st == seq_pkg::ST_RUN);

endmodule : dual_regulator_sequencer_irq

// ==== verif/host_pin_model.sv ====
// host side model: drives the sequence enable pin after a programmable lag
// assumes pinReq changes just after a rising clock edge
`timescale 1ns/100ps
module host_pin_model (
  input  wire logic       clock,
  input  wire logic       rst_b,
  input  wire logic       pinReq,
  input  wire logic [1:0] lag,
  output logic            seqEnablePin
);
  logic [1:0] waitCnt;
  // pin pulled low by default, follows the request lag+1 cycles after it changes
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      seqEnablePin <= 1'b0;
      waitCnt      <= 2'h0;
    end else if (pinReq == seqEnablePin) begin
      waitCnt <= 2'h0;
    end else if (waitCnt >= lag) begin
      seqEnablePin <= pinReq;
    end else begin
      waitCnt <= waitCnt + 2'h1;
    end
  end
endmodule : host_pin_model

// ==== verif/sequencer_chk.sv ====
// concurrent checks on the sequencer ports
// assumes one clock domain and the bind at the foot of this file
`timescale 1ns/100ps
module sequencer_chk #(
  parameter int unsigned MS_CYCLES = 10,
  parameter int unsigned SC_CYCLES = 5
) (
  input wire logic       clock,
  input wire logic       rst_b,
  input wire logic       softResetBit,
  input wire logic       analogSupplyLow,
  input wire logic [1:0] regulatorOnBit,
  input wire logic [1:0] auxOutputOnBit,
  input wire logic       railsOkPolarity,
  input wire logic [1:0] regulatorEnable,
  input wire logic [7:0] regulatorVoltage0,
  input wire logic       auxOutput0,
  input wire logic       auxOutput1,
  input wire logic       irqOutN,
  input wire logic       railsOkPin,
  input wire logic       railsOkState,
  input wire logic [1:0] shortCircuitFlag,
  input wire logic       hotShutdownFlag,
  input wire logic       supplyOvervoltFlag,
  input wire logic       resetIndicationFlag,
  input wire logic       deviceRunning
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  wire logic [3:0] outs = {auxOutput1, auxOutput0, regulatorEnable};
  wire logic       hard = |shortCircuitFlag | supplyOvervoltFlag | hotShutdownFlag;
  wire logic       quiet = !softResetBit && !analogSupplyLow;

  chk_volt_zero: assert property (!regulatorEnable[0] |-> regulatorVoltage0 == 8'h00)
    else $error("voltage code shown while regulator off");
  chk_bit_off: assert property (!regulatorOnBit[0] |=> !regulatorEnable[0])
    else $error("regulator on with its on bit clear");
  chk_aux_off: assert property (!auxOutputOnBit[1] |=> !auxOutput1)
    else $error("aux output high with its on bit clear");
  chk_soft_kill: assert property (softResetBit |=> outs == 4'h0 && !deviceRunning)
    else $error("outputs alive after soft reset");
  chk_uv_kill: assert property (analogSupplyLow |=> outs == 4'h0 && !deviceRunning)
    else $error("outputs alive under low supply");
  chk_uv_restart: assert property ($fell(analogSupplyLow) |-> ##[1:4] deviceRunning)
    else $error("no restart after supply recovery");
  chk_ovp_kill: assert property (supplyOvervoltFlag |=> outs == 4'h0)
    else $error("outputs alive with overvoltage flag");
  chk_hot_kill: assert property (hotShutdownFlag |=> outs == 4'h0)
    else $error("outputs alive with hot shutdown flag");
  chk_sc_off: assert property (shortCircuitFlag[0] |-> !regulatorEnable[0])
    else $error("regulator on with short circuit flag");
  chk_irq_hard: assert property ((hard || resetIndicationFlag) && quiet |=> !irqOutN)
    else $error("irq idle with unmaskable flag pending");
  chk_pin_pol: assert property ($past(deviceRunning) && deviceRunning
    |-> railsOkPin == (railsOkState ^ $past(railsOkPolarity)))
    else $error("rails pin not state xor polarity");

  cover property ($rose(regulatorEnable[0]));
  cover property ($fell(irqOutN));
  cover property ($rose(shortCircuitFlag[0]));
endmodule : sequencer_chk

bind dual_regulator_sequencer_irq sequencer_chk #(
  .MS_CYCLES(MS_CYCLES),
  .SC_CYCLES(SC_CYCLES)
) u_chk (.*);

// ==== verif/dual_regulator_sequencer_irq_bench.sv ====
// self-checking bench for the dual regulator sequencer
// assumes the host pin model and the bound checker
`timescale 1ns/100ps
module dual_regulator_sequencer_irq_bench;
  localparam int MSC = 10;
  localparam int SCC = 5;
  localparam logic [11:0] CM [4] = '{12'h100, 12'h080, 12'h003, 12'h040};
  logic clock, rst_b, seqEnablePin, analogSupplyLow, softResetBit, otpResetMask, pinReq;
  logic [1:0] regulatorOnBit, regulatorPinSelect, auxOutputOnBit, auxOutputPinSelect, lag;
  logic [7:0] regulatorVoltageCode0, regulatorVoltageCode1, regulatorVoltage0, regulatorVoltage1;
  logic [3:0] regulatorRiseDelay0, regulatorRiseDelay1, regulatorFallDelay0, regulatorFallDelay1;
  logic [3:0] auxOutputRiseDelay0, auxOutputRiseDelay1, auxOutputFallDelay0, auxOutputFallDelay1;
  logic [1:0] currentLimitIn, outputLow, outputValidIn, currentLimitMask, outputValidRiseMask;
  logic [1:0] outputValidFallMask, currentLimitClear, shortCircuitClear, outputValidChangeClear;
  logic hotWarningIn, hotShutdownIn, supplyOvervoltIn, clockDetectEnable, extClockPresent;
  logic hotWarningMask, railsOkDropMask, extClockMask, railsOkPolarity, hotWarningClear;
  logic hotShutdownClear, supplyOvervoltClear, railsOkDropClear, extClockClear;
  logic resetIndicationClear, auxOutput0, auxOutput1, irqOutN, railsOkPin, railsOkState;
  logic [1:0] regulatorEnable, currentLimitState, outputValidState, currentLimitFlag;
  logic [1:0] shortCircuitFlag, outputValidChangeFlag;
  logic hotWarningState, hotShutdownState, supplyOvervoltState, extClockState, hotWarningFlag;
  logic hotShutdownFlag, supplyOvervoltFlag, railsOkDropFlag, extClockFlag;
  logic resetIndicationFlag, deviceRunning, evMask, vMask;
  logic [15:0] riseDly, fallDly;
  logic [3:0]  pinSel, onBits, evSrc;
  logic [11:0] clrBits;
  int n_mismatch, comparisons;
  wire logic [3:0] outs = {auxOutput1, auxOutput0, regulatorEnable};
  wire logic [3:0] evFlag = {hotWarningFlag, currentLimitFlag[0], hotShutdownFlag,
                             supplyOvervoltFlag};
  wire logic [3:0] evState = {hotWarningState, currentLimitState[0], hotShutdownState,
                              supplyOvervoltState};
  assign {auxOutputRiseDelay1, auxOutputRiseDelay0,
          regulatorRiseDelay1, regulatorRiseDelay0} = riseDly;
  assign {auxOutputFallDelay1, auxOutputFallDelay0,
          regulatorFallDelay1, regulatorFallDelay0} = fallDly;
  assign {auxOutputPinSelect, regulatorPinSelect} = pinSel;
  assign {auxOutputOnBit, regulatorOnBit} = onBits;
  assign {resetIndicationClear, extClockClear, railsOkDropClear, supplyOvervoltClear,
          hotShutdownClear, hotWarningClear, outputValidChangeClear, shortCircuitClear,
          currentLimitClear} = clrBits;
  assign {hotWarningIn, hotShutdownIn, supplyOvervoltIn} = {evSrc[3], evSrc[1], evSrc[0]};
  assign currentLimitIn = {2{evSrc[2]}};
  assign currentLimitMask = {2{evMask}};
  assign hotWarningMask = evMask;
  assign outputValidRiseMask = {1'b0, vMask};
  assign outputValidFallMask = {1'b0, ~vMask};

  dual_regulator_sequencer_irq #(.MS_CYCLES(MSC), .SC_CYCLES(SCC)) u_dut (.*);
  host_pin_model u_host (.clock(clock), .rst_b(rst_b), .pinReq(pinReq), .lag(lag),
                         .seqEnablePin(seqEnablePin));

  always #10 clock = ~clock;

  task cmp(string nm, logic [7:0] exp, logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : cmp

  task wt(int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : wt

  task clear(logic [11:0] m);
    @(posedge clock) clrBits <= m;
    @(posedge clock) clrBits <= 12'h000;
  endtask : clear

  // cycle of first output change after the pin edge
  function automatic logic seq_ok(int c, logic lvl, int n);
    int d;
    d = lvl ? riseDly[4*c+:4] : fallDly[4*c+:4];
    if (!pinSel[c]) return n == (lvl ? 1 : 0);
    if (d == 0) return n == 3;
    return n >= d * MSC + 2 && n <= d * MSC + 4;
  endfunction : seq_ok

  task seq_run(logic lvl);
    int first [4];
    first = '{default: 0};
    @(posedge clock) pinReq <= lvl;
    for (int i = 0; i < 8 && seqEnablePin !== lvl; i++) wt(1);
    for (int n = 1; n < 50; n++) begin
      wt(1);
      for (int c = 0; c < 4; c++) if (first[c] == 0 && outs[c] === lvl) first[c] = n;
    end
    for (int c = 0; c < 4; c++)
      cmp("seq_edge", 1, seq_ok(c, lvl, first[c]));
  endtask : seq_run

  task close_out;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : close_out

  initial begin
    #(20 * 20000);
    n_mismatch++;
    close_out();
  end

  initial begin
    void'($urandom(87856));
    {clock, rst_b, analogSupplyLow, softResetBit, pinReq, lag, outputLow} = '0;
    {clockDetectEnable, extClockPresent, evMask, vMask, evSrc, clrBits, pinSel} = '0;
    {riseDly, fallDly} = '0;
    onBits = 4'hF;
    outputValidIn = 2'b11;
    {otpResetMask, railsOkPolarity, railsOkDropMask, extClockMask} = 4'($urandom);
    regulatorVoltageCode0 = 8'($urandom);
    regulatorVoltageCode1 = 8'($urandom);
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    wt(4);
    cmp("running", 1, deviceRunning);
    cmp("reset_flag", !otpResetMask, resetIndicationFlag);
    for (int it = 0; it < 3; it++) begin
      @(posedge clock);
      riseDly <= (it == 0) ? 16'h0300 : 16'($urandom) & 16'h3333;
      fallDly <= (it == 0) ? 16'h3003 : 16'($urandom) & 16'h3333;
      pinSel <= (it == 0) ? 4'hF : 4'($urandom);
      lag <= 2'($urandom);
      wt(3);
      seq_run(1'b1);
      cmp("volt0", regulatorVoltageCode0, regulatorVoltage0);
      cmp("volt1", regulatorVoltageCode1, regulatorVoltage1);
      seq_run(1'b0);
    end
    @(posedge clock) {pinSel, onBits} <= 8'h00;
    wt(2);
    cmp("bit_off", 4'h0, outs);
    @(posedge clock) onBits <= 4'hF;
    wt(2);
    cmp("bit_on", 4'hF, outs);
    for (int k = 0; k < 4; k++) begin
      clear(12'hFFF);
      @(posedge clock) {evSrc, evMask} <= {4'h1 << k, 1'($urandom)};
      wt(4);
      cmp("ev_flag", 1, evFlag[k]);
      cmp("ev_state", 1, evState[k]);
      cmp("ev_kill", (k < 2) ? 4'h0 : 4'hF, outs);
      cmp("ev_irq", (k < 2) ? 1'b0 : evMask, irqOutN);
      clear(CM[k]);
      wt(1);
      cmp("ev_sticky", 1, evFlag[k]);
      @(posedge clock) evSrc <= 4'h0;
      wt(2);
      clear(CM[k] | 12'h200);
      wt(2);
      cmp("ev_clear", 0, evFlag[k]);
      cmp("irq_idle", 1, irqOutN);
      cmp("restored", 4'hF, outs);
    end
    cmp("rails_state", 1, railsOkState);
    cmp("rails_pin", !railsOkPolarity, railsOkPin);
    @(posedge clock) outputLow <= 2'b01;
    wt(SCC + 4);
    cmp("sc_flag", 1, shortCircuitFlag[0]);
    cmp("sc_off", 0, regulatorEnable[0]);
    @(posedge clock) outputLow <= 2'b00;
    wt(2);
    clear(12'h204);
    wt(3);
    cmp("sc_back", 1, regulatorEnable[0]);
    for (int i = 0; i < 4; i++) begin
      @(posedge clock) vMask <= 1'($urandom);
      @(posedge clock) outputValidIn[0] <= i[0];
      wt(3);
      cmp("valid_flag", i[0] ? !vMask : vMask, outputValidChangeFlag[0]);
      cmp("valid_state", i[0], outputValidState[0]);
      if (!i[0]) cmp("drop_flag", 1, railsOkDropFlag);
      clear(12'h230);
      wt(2);
      cmp("valid_clr", 0, outputValidChangeFlag[0]);
    end
    @(posedge clock) clockDetectEnable <= 1'b1;
    wt(3);
    cmp("clk_flag", 1, extClockFlag);
    @(posedge clock) extClockPresent <= 1'b1;
    @(posedge clock) clockDetectEnable <= 1'b0;
    clear(12'h400);
    wt(2);
    cmp("clk_clr", 0, extClockFlag);
    cmp("clk_state", 1, extClockState);
    @(posedge clock) {otpResetMask, softResetBit} <= {1'($urandom), 1'b1};
    @(posedge clock) softResetBit <= 1'b0;
    wt(5);
    cmp("soft_run", 1, deviceRunning);
    cmp("soft_flag", !otpResetMask, resetIndicationFlag);
    @(posedge clock) analogSupplyLow <= 1'b1;
    wt(4);
    cmp("uv_off", 0, outs);
    @(posedge clock) analogSupplyLow <= 1'b0;
    wt(6);
    cmp("uv_up", 4'hF, outs);
    cmp("uv_flag", !otpResetMask, resetIndicationFlag);
    close_out();
  end
endmodule : dual_regulator_sequencer_irq_bench
